// ==== design/adc_control_register_bank.sv ====
`timescale 1ns/1ps
module adc_control_register_bank #(
    parameter int SYNC_CYCLES = adc_regs_pkg::SYNC_CYCLES,
    parameter int HALF_PERIOD_CYCLES = adc_regs_pkg::HALF_PERIOD_CYCLES
) (
    // clock and reset
    input wire logic MCLK,
    input wire logic RST_N,
    // register port
    input wire logic [adc_regs_pkg::ADDR_W-1:0] ADDR,
    input wire logic [1:0] SIZE,
    input wire logic [31:0] WDATA,
    input wire logic WR_STB,
    input wire logic RD_STB,
    output logic [31:0] RDATA,
    output logic STALL,
    // system
    input wire logic PERIPHERAL_ACCESS_GUARD_LOCK,
    input wire logic STANDBY,
    // converter side
    input wire logic RESULT_VALID,
    input wire logic [15:0] RESULT_DATA,
    input wire logic OVERRUN_HIT,
    input wire logic WINDOW_HIT,
    input wire logic SAMPLE_START,
    output logic CONV_ENABLED,
    output logic CONV_RUN,
    output logic REF_BUFFER_COMP_EN,
    output logic [3:0] REFERENCE_SELECT,
    output logic REFERENCE_SELECT_OK,
    output logic [2:0] RESULT_SHIFT_COEFF,
    output logic [3:0] ACCUMULATE_COUNT,
    output logic ACCUMULATE_COUNT_OK,
    output logic SAMPLING,
    output logic SAMPLE_DONE,
    output logic [15:0] WIN_LOWER,
    output logic [15:0] WIN_UPPER,
    output logic [11:0] GAIN_CORR,
    output logic [11:0] OFFSET_CORR,
    output logic [10:0] ANALOG_CALIBRATION_VALUE,
    output logic DEBUG_RUN,
    // events
    input wire logic START_EVENT,
    input wire logic FLUSH_EVENT,
    output logic EVT_START_CONV,
    output logic EVT_FLUSH,
    output logic EVT_RESULT_READY,
    output logic EVT_WINDOW,
    // interrupt
    output logic IRQ
);

    // ========================================
    // state and helpers
    adc_regs_pkg::bank_state_t st;
    adc_regs_pkg::bank_state_t next_st;
    logic sync_busy;
    logic sync_done;
    logic sync_load;
    logic samp_done;
    logic half_tick;
    logic [3:0] lanes;
    logic sync_access;

    // byte lanes selected by size and low address bits
    function automatic logic [3:0] lane_mask(input logic [1:0] size, input logic [1:0] a);
        logic [3:0] m;
        m = 4'h0;
        unique case (size)
            adc_regs_pkg::SIZE_BYTE: m = 4'h1 << a;
            adc_regs_pkg::SIZE_HALF: m = a[1] ? 4'hC : 4'h3;
            default: m = 4'hF;
        endcase
        return m;
    endfunction : lane_mask

    function automatic logic [5:0] lane_addr(input logic [5:0] a, input int i);
        return {a[5:2], 2'(i)};
    endfunction : lane_addr

    // does the access touch a synchronized byte
    function automatic logic needs_sync(input logic [5:0] a, input logic [3:0] m);
        logic r;
        logic [5:0] b;
        r = 1'b0;
        for (int i = 0; i < 4; i++) begin
            b = lane_addr(a, i);
            if (m[i] && (b == adc_regs_pkg::OFS_CORE_CONTROL
                || b[5:1] == adc_regs_pkg::OFS_WINDOW_LOWER[5:1]
                || b[5:1] == adc_regs_pkg::OFS_WINDOW_UPPER[5:1])) begin
                r = 1'b1;
            end
        end
        return r;
    endfunction : needs_sync

    // read one byte of the map
    function automatic logic [7:0] read_byte(input adc_regs_pkg::bank_state_t s,
                                             input logic [5:0] b, input logic busy);
        logic [7:0] d;
        d = 8'h00;
        unique case (b)
            adc_regs_pkg::OFS_CORE_CONTROL: d = {5'h00, s.run_in_standby, s.enable,
                                                 s.soft_reset_request};
            adc_regs_pkg::OFS_REFERENCE_CONTROL: d = s.reference_control;
            adc_regs_pkg::OFS_AVERAGING_CONTROL: d = s.averaging_control;
            adc_regs_pkg::OFS_SAMPLE_TIME_CONTROL: d = {2'h0, s.sample_phase_length};
            adc_regs_pkg::OFS_EVENT_CONTROL: d = s.event_control;
            adc_regs_pkg::OFS_IRQ_ENABLE_CLEAR: d = {4'h0, s.irq_enable};
            adc_regs_pkg::OFS_IRQ_ENABLE_SET: d = {4'h0, s.irq_enable};
            adc_regs_pkg::OFS_IRQ_FLAGS: d = {4'h0, s.irq_flags};
            adc_regs_pkg::OFS_SYNC_STATUS: d = {busy, 7'h00};
            6'h1A: d = s.result[7:0];
            6'h1B: d = s.result[15:8];
            6'h1C: d = s.win_lower[7:0];
            6'h1D: d = s.win_lower[15:8];
            6'h20: d = s.win_upper[7:0];
            6'h21: d = s.win_upper[15:8];
            6'h24: d = s.gain[7:0];
            6'h25: d = s.gain[15:8];
            6'h26: d = s.offset[7:0];
            6'h27: d = s.offset[15:8];
            6'h28: d = s.analog_calibration[7:0];
            6'h29: d = s.analog_calibration[15:8];
            adc_regs_pkg::OFS_DEBUG_CONTROL: d = {7'h00, s.debug_run};
            default: d = 8'h00;
        endcase
        return d;
    endfunction : read_byte

    // apply one write access to the bank
    function automatic adc_regs_pkg::bank_state_t apply_write(
            input adc_regs_pkg::bank_state_t s, input logic [5:0] a,
            input logic [31:0] wd, input logic [3:0] m, input logic lock);
        adc_regs_pkg::bank_state_t r;
        logic [5:0] b;
        logic [7:0] d;
        logic ep;
        r = s;
        ep = s.enable;
        if (m[0] && a[5:2] == 4'h0 && wd[adc_regs_pkg::BIT_SOFT_RESET] && !lock) begin
            r.soft_reset_request = 1'b1;
            r.enable = 1'b0;
            return r;
        end
        for (int i = 0; i < 4; i++) begin
            b = lane_addr(a, i);
            d = wd[8*i +: 8];
            if (m[i]) begin
                unique case (b)
                    adc_regs_pkg::OFS_CORE_CONTROL: if (!lock) begin
                        r.enable = d[adc_regs_pkg::BIT_ENABLE];
                        r.run_in_standby = d[adc_regs_pkg::BIT_RUN_IN_STANDBY];
                    end
                    adc_regs_pkg::OFS_REFERENCE_CONTROL: if (!lock) begin
                        r.reference_control = d & adc_regs_pkg::MASK_REFERENCE_CONTROL;
                    end
                    adc_regs_pkg::OFS_AVERAGING_CONTROL: if (!lock) begin
                        r.averaging_control = d & adc_regs_pkg::MASK_AVERAGING_CONTROL;
                    end
                    adc_regs_pkg::OFS_SAMPLE_TIME_CONTROL: if (!lock) begin
                        r.sample_phase_length = d[5:0];
                    end
                    adc_regs_pkg::OFS_EVENT_CONTROL: if (!lock && !ep) begin
                        r.event_control = d & adc_regs_pkg::MASK_EVENT_CONTROL;
                    end
                    adc_regs_pkg::OFS_IRQ_ENABLE_CLEAR: r.irq_enable = r.irq_enable & ~d[3:0];
                    adc_regs_pkg::OFS_IRQ_ENABLE_SET: r.irq_enable = r.irq_enable | d[3:0];
                    adc_regs_pkg::OFS_IRQ_FLAGS: r.irq_flags = r.irq_flags & ~d[3:0];
                    6'h1C: if (!lock) r.win_lower[7:0] = d;
                    6'h1D: if (!lock) r.win_lower[15:8] = d;
                    6'h20: if (!lock) r.win_upper[7:0] = d;
                    6'h21: if (!lock) r.win_upper[15:8] = d;
                    6'h24: if (!lock) r.gain[7:0] = d;
                    6'h25: if (!lock) r.gain[15:8] = d & adc_regs_pkg::MASK_HIGH_NIBBLE12;
                    6'h26: if (!lock) r.offset[7:0] = d;
                    6'h27: if (!lock) r.offset[15:8] = d & adc_regs_pkg::MASK_HIGH_NIBBLE12;
                    6'h28: if (!lock) r.analog_calibration[7:0] = d;
                    6'h29: if (!lock) r.analog_calibration[15:8] = d & adc_regs_pkg::MASK_ANALOG_CALIBRATION_HIGH;
                    adc_regs_pkg::OFS_DEBUG_CONTROL: if (!lock) r.debug_run = d[0];
                    default: r = r;
                endcase
            end
        end
        return r;
    endfunction : apply_write

    // ========================================
    // next state
    assign lanes = lane_mask(SIZE, ADDR[1:0]);
    assign sync_access = needs_sync(ADDR, lanes) && !PERIPHERAL_ACCESS_GUARD_LOCK;

    always_comb begin
        next_st = st;
        sync_load = 1'b0;
        // converter half-period divider
        half_tick = 1'b0;
        if (st.half_cnt >= 8'(HALF_PERIOD_CYCLES - 1)) begin
            next_st.half_cnt = 8'h00;
            half_tick = 1'b1;
        end else begin
            next_st.half_cnt = st.half_cnt + 8'h01;
        end
        // completion of a synchronized operation
        if (sync_done) begin
            if (st.soft_reset_request) begin
                next_st = adc_regs_pkg::BANK_RESET;
                next_st.debug_run = st.debug_run;
                next_st.half_cnt = st.half_cnt;
                next_st.pend = st.pend;
                next_st.pend_addr = st.pend_addr;
                next_st.pend_data = st.pend_data;
                next_st.pend_lanes = st.pend_lanes;
            end else begin
                next_st.conv_enabled = st.enable;
            end
        end
        // held write proceeds once the bank is idle again
        if (st.pend && !sync_busy && !sync_done) begin
            next_st = apply_write(next_st, st.pend_addr, st.pend_data, st.pend_lanes,
                                  PERIPHERAL_ACCESS_GUARD_LOCK);
            next_st.pend = 1'b0;
            sync_load = 1'b1;
        end
        if (WR_STB) begin
            if (sync_access && (sync_busy || st.pend)) begin
                next_st.pend = 1'b1;
                next_st.pend_addr = ADDR;
                next_st.pend_data = WDATA;
                next_st.pend_lanes = lanes;
            end else begin
                next_st = apply_write(next_st, ADDR, WDATA, lanes,
                                      PERIPHERAL_ACCESS_GUARD_LOCK);
                sync_load = sync_load || sync_access;
            end
        end
        // hardware sets win over clears
        if (RESULT_VALID) begin
            next_st.result = RESULT_DATA;
            next_st.irq_flags[adc_regs_pkg::IRQ_RESULT_READY] = 1'b1;
        end
        if (OVERRUN_HIT) begin
            next_st.irq_flags[adc_regs_pkg::IRQ_OVERRUN] = 1'b1;
        end
        if (WINDOW_HIT) begin
            next_st.irq_flags[adc_regs_pkg::IRQ_WINDOW] = 1'b1;
        end
        if (sync_done) begin
            next_st.irq_flags[adc_regs_pkg::IRQ_SYNC_READY] = 1'b1;
        end
        // read data for the following cycle
        next_st.rdata = 32'h0000_0000;
        if (RD_STB) begin
            for (int i = 0; i < 4; i++) begin
                if (lanes[i]) begin
                    next_st.rdata[8*i +: 8] = read_byte(st, lane_addr(ADDR, i), sync_busy);
                end
            end
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            st <= adc_regs_pkg::BANK_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ========================================
    // synchronizer delay toward the converter
    adc_countdown #(
        .W(8)
    ) u_sync (
        .clk(MCLK),
        .rst_n(RST_N),
        .load(sync_load),
        .value(8'(SYNC_CYCLES)),
        .tick(1'b1),
        .busy(sync_busy),
        .done(sync_done)
    );

    // ========================================
    // sampling phase timer
    adc_countdown #(
        .W(7)
    ) u_sample (
        .clk(MCLK),
        .rst_n(RST_N),
        .load(SAMPLE_START && CONV_RUN),
        .value({1'b0, st.sample_phase_length} + 7'h01),
        .tick(half_tick),
        .busy(SAMPLING),
        .done(samp_done)
    );

    // ========================================
    // outputs
    assign RDATA = st.rdata;
    assign STALL = st.pend;
    assign CONV_ENABLED = st.conv_enabled;
    assign CONV_RUN = st.conv_enabled && (!STANDBY || st.run_in_standby);
    assign REF_BUFFER_COMP_EN = st.reference_control[adc_regs_pkg::BIT_REF_COMP];
    assign REFERENCE_SELECT = st.reference_control[3:0];
    assign REFERENCE_SELECT_OK = st.reference_control[3:0] <= adc_regs_pkg::REF_EXTERNAL_B;
    assign RESULT_SHIFT_COEFF = st.averaging_control[6:4];
    assign ACCUMULATE_COUNT = st.averaging_control[3:0];
    assign ACCUMULATE_COUNT_OK = st.averaging_control[3:0] <= adc_regs_pkg::ACCUM_CODE_MAX;
    assign SAMPLE_DONE = samp_done;
    assign WIN_LOWER = st.win_lower;
    assign WIN_UPPER = st.win_upper;
    assign GAIN_CORR = st.gain[11:0];
    assign OFFSET_CORR = st.offset[11:0];
    assign ANALOG_CALIBRATION_VALUE = st.analog_calibration[10:0];
    assign DEBUG_RUN = st.debug_run;
    assign EVT_START_CONV = START_EVENT && st.event_control[adc_regs_pkg::EVC_START_IN]
                            && CONV_RUN;
    assign EVT_FLUSH = FLUSH_EVENT && st.event_control[adc_regs_pkg::EVC_FLUSH_IN]
                       && st.conv_enabled;
    assign EVT_RESULT_READY = RESULT_VALID && st.event_control[adc_regs_pkg::EVC_RESULT_OUT];
    assign EVT_WINDOW = WINDOW_HIT && st.event_control[adc_regs_pkg::EVC_WINDOW_OUT];
    assign IRQ = |(st.irq_flags & st.irq_enable);

endmodule : adc_control_register_bank

// ==== design/adc_regs_pkg.sv ====
package adc_regs_pkg;

    // ========================================
    // bus geometry
    localparam int ADDR_W = 6;
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;

    // ========================================
    // register byte offsets
    localparam logic [5:0] OFS_CORE_CONTROL = 6'h00;
    localparam logic [5:0] OFS_REFERENCE_CONTROL = 6'h01;
    localparam logic [5:0] OFS_AVERAGING_CONTROL = 6'h02;
    localparam logic [5:0] OFS_SAMPLE_TIME_CONTROL = 6'h03;
    localparam logic [5:0] OFS_EVENT_CONTROL = 6'h14;
    localparam logic [5:0] OFS_IRQ_ENABLE_CLEAR = 6'h16;
    localparam logic [5:0] OFS_IRQ_ENABLE_SET = 6'h17;
    localparam logic [5:0] OFS_IRQ_FLAGS = 6'h18;
    localparam logic [5:0] OFS_SYNC_STATUS = 6'h19;
    localparam logic [5:0] OFS_CONVERSION_RESULT = 6'h1A;
    localparam logic [5:0] OFS_WINDOW_LOWER = 6'h1C;
    localparam logic [5:0] OFS_WINDOW_UPPER = 6'h20;
    localparam logic [5:0] OFS_GAIN_CORRECTION = 6'h24;
    localparam logic [5:0] OFS_OFFSET_CORRECTION = 6'h26;
    localparam logic [5:0] OFS_ANALOG_CALIBRATION = 6'h28;
    localparam logic [5:0] OFS_DEBUG_CONTROL = 6'h2A;

    // ========================================
    // field positions and masks
    localparam int BIT_SOFT_RESET = 0;
    localparam int BIT_ENABLE = 1;
    localparam int BIT_RUN_IN_STANDBY = 2;
    localparam int BIT_REF_COMP = 7;
    localparam int BIT_SYNC_BUSY = 7;
    localparam int IRQ_RESULT_READY = 0;
    localparam int IRQ_OVERRUN = 1;
    localparam int IRQ_WINDOW = 2;
    localparam int IRQ_SYNC_READY = 3;
    localparam int EVC_START_IN = 0;
    localparam int EVC_FLUSH_IN = 1;
    localparam int EVC_RESULT_OUT = 4;
    localparam int EVC_WINDOW_OUT = 5;
    localparam logic [7:0] MASK_EVENT_CONTROL = 8'h33;
    localparam logic [7:0] MASK_REFERENCE_CONTROL = 8'h8F;
    localparam logic [7:0] MASK_AVERAGING_CONTROL = 8'h7F;
    localparam logic [7:0] MASK_SAMPLE_TIME = 8'h3F;
    localparam logic [7:0] MASK_HIGH_NIBBLE12 = 8'h0F;
    localparam logic [7:0] MASK_ANALOG_CALIBRATION_HIGH = 8'h07;

    // ========================================
    // field encodings
    localparam logic [3:0] REF_INTERNAL_ONE_VOLT = 4'h0;
    localparam logic [3:0] REF_SUPPLY_RATIO_A = 4'h1;
    localparam logic [3:0] REF_SUPPLY_HALF = 4'h2;
    localparam logic [3:0] REF_EXTERNAL_A = 4'h3;
    localparam logic [3:0] REF_EXTERNAL_B = 4'h4;
    localparam logic [3:0] ACCUM_CODE_MAX = 4'hA;

    // ========================================
    // timing
    localparam int SYNC_CYCLES = 4;
    localparam int HALF_PERIOD_CYCLES = 2;

    // ========================================
    // bank state
    typedef struct packed {
        logic run_in_standby;
        logic enable;
        logic conv_enabled;
        logic soft_reset_request;
        logic [7:0] reference_control;
        logic [7:0] averaging_control;
        logic [5:0] sample_phase_length;
        logic [7:0] event_control;
        logic [3:0] irq_enable;
        logic [3:0] irq_flags;
        logic [15:0] result;
        logic [15:0] win_lower;
        logic [15:0] win_upper;
        logic [15:0] gain;
        logic [15:0] offset;
        logic [15:0] analog_calibration;
        logic debug_run;
        logic pend;
        logic [5:0] pend_addr;
        logic [31:0] pend_data;
        logic [3:0] pend_lanes;
        logic [7:0] half_cnt;
        logic [31:0] rdata;
    } bank_state_t;

    localparam bank_state_t BANK_RESET = '0;

endpackage : adc_regs_pkg

// ==== design/adc_countdown.sv ====
`timescale 1ns/1ps
module adc_countdown #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic load,
    input wire logic [W-1:0] value,
    input wire logic tick,
    // status
    output logic busy,
    output logic done
);

    // ========================================
    // state
    typedef struct packed {
        logic busy;
        logic [W-1:0] count;
    } cnt_state_t;

    cnt_state_t st;
    cnt_state_t next_st;

    always_comb begin
        next_st = st;
        done = 1'b0;
        if (load) begin
            next_st.busy = 1'b1;
            next_st.count = value;
        end else if (st.busy && tick) begin
            if (st.count <= W'(1)) begin
                next_st.busy = 1'b0;
                next_st.count = '0;
                done = 1'b1;
            end else begin
                next_st.count = st.count - W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign busy = st.busy;

endmodule : adc_countdown

// ==== verification/adc_control_register_bank_assertions.sv ====
`timescale 1ns/1ps
// ========================================
// port checker
module adc_bank_checker (
    // clock and reset
    input wire logic MCLK,
    input wire logic RST_N,
    // register port
    input wire logic [adc_regs_pkg::ADDR_W-1:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR_STB,
    input wire logic RD_STB,
    input wire logic [31:0] RDATA,
    input wire logic STALL,
    // system
    input wire logic PERIPHERAL_ACCESS_GUARD_LOCK,
    input wire logic STANDBY,
    // converter side
    input wire logic CONV_ENABLED,
    input wire logic CONV_RUN,
    input wire logic [3:0] REFERENCE_SELECT,
    input wire logic REFERENCE_SELECT_OK,
    input wire logic [3:0] ACCUMULATE_COUNT,
    input wire logic ACCUMULATE_COUNT_OK,
    input wire logic SAMPLING
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    wire logic ctl_wr = WR_STB && ADDR == 6'h00 && !PERIPHERAL_ACCESS_GUARD_LOCK;

    property p_rdata_idle; !$past(RD_STB) |-> RDATA == 32'h0; endproperty
    property p_reference_select_ok; REFERENCE_SELECT_OK == (REFERENCE_SELECT <= 4'h4); endproperty
    property p_accum_ok; ACCUMULATE_COUNT_OK == (ACCUMULATE_COUNT <= 4'hA); endproperty
    property p_run_awake; CONV_ENABLED && !STANDBY |-> CONV_RUN; endproperty
    property p_run_needs_en; CONV_RUN |-> CONV_ENABLED; endproperty
    property p_lock_holds;
        WR_STB && PERIPHERAL_ACCESS_GUARD_LOCK && ADDR == 6'h01 && !STALL |=> $stable(REFERENCE_SELECT);
    endproperty
    property p_stall_ends; $rose(STALL) |-> ##[1:12] !STALL; endproperty
    property p_enable_lands; ctl_wr && WDATA[1:0] == 2'h2 |-> ##[1:12] CONV_ENABLED; endproperty
    property p_reset_disables; ctl_wr && WDATA[0] |-> ##[1:12] !CONV_ENABLED; endproperty
    property p_sample_ends; $rose(SAMPLING) |-> ##[1:200] !SAMPLING; endproperty

    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero outside read cycle");
    a_reference_select_ok: assert property (p_reference_select_ok)
        else $error("reference select valid flag wrong");
    a_accum_ok: assert property (p_accum_ok)
        else $error("accumulate count valid flag wrong");
    a_run_awake: assert property (p_run_awake)
        else $error("enabled converter not running while awake");
    a_run_needs_en: assert property (p_run_needs_en)
        else $error("converter running while disabled");
    a_lock_holds: assert property (p_lock_holds)
        else $error("guarded register changed under lock");
    a_stall_ends: assert property (p_stall_ends)
        else $error("held write never completed");
    a_enable_lands: assert property (p_enable_lands)
        else $error("converter not enabled after enable write");
    a_reset_disables: assert property (p_reset_disables)
        else $error("converter not disabled after soft reset");
    a_sample_ends: assert property (p_sample_ends)
        else $error("sampling phase too long");

    c_stall: cover property ($rose(STALL));
    c_disable: cover property ($fell(CONV_ENABLED));
    c_sample: cover property ($rose(SAMPLING));
endmodule : adc_bank_checker

bind adc_control_register_bank adc_bank_checker adc_bank_checker_i (.MCLK, .RST_N, .ADDR,
    .WDATA, .WR_STB, .RD_STB, .RDATA, .STALL, .PERIPHERAL_ACCESS_GUARD_LOCK, .STANDBY,
    .CONV_ENABLED, .CONV_RUN, .REFERENCE_SELECT, .REFERENCE_SELECT_OK, .ACCUMULATE_COUNT,
    .ACCUMULATE_COUNT_OK, .SAMPLING);

// ==== verification/tb_adc_control_register_bank.sv ====
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin errors++; \
    $display("FAIL %s exp %0h got %0h", nm, e, g); end end
// ========================================
// bench top
module tb_adc_control_register_bank;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [5:0] addr = 6'h00;
    logic [1:0] size = 2'h0;
    logic [31:0] wdata = 32'h0;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic lock = 1'b0;
    logic standby = 1'b0;
    logic [15:0] res_data = 16'h0;
    logic [5:0] ev = 6'h00;
    logic [31:0] rdata;
    logic stall, conv_en, conv_run, ref_comp, ref_ok, acc_ok, sampling, dbg, irq;
    logic [3:0] ref_sel, acc_cnt, evt;
    logic [2:0] shift;
    logic [15:0] win_lo;
    int errors = 0;
    int check_count = 0;
    int cyc = 0;
    localparam int SC = adc_regs_pkg::SYNC_CYCLES;

    adc_control_register_bank adc_control_register_bank_i (.MCLK(mclk), .RST_N(rst_n),
        .ADDR(addr), .SIZE(size), .WDATA(wdata), .WR_STB(wr_stb), .RD_STB(rd_stb),
        .RDATA(rdata), .STALL(stall), .PERIPHERAL_ACCESS_GUARD_LOCK(lock), .STANDBY(standby),
        .RESULT_VALID(ev[0]), .RESULT_DATA(res_data), .OVERRUN_HIT(ev[1]),
        .WINDOW_HIT(ev[2]), .SAMPLE_START(ev[3]), .CONV_ENABLED(conv_en),
        .CONV_RUN(conv_run), .REF_BUFFER_COMP_EN(ref_comp), .REFERENCE_SELECT(ref_sel),
        .REFERENCE_SELECT_OK(ref_ok), .RESULT_SHIFT_COEFF(shift), .ACCUMULATE_COUNT(acc_cnt),
        .ACCUMULATE_COUNT_OK(acc_ok), .SAMPLING(sampling), .SAMPLE_DONE(),
        .WIN_LOWER(win_lo), .WIN_UPPER(), .GAIN_CORR(), .OFFSET_CORR(), .ANALOG_CALIBRATION_VALUE(),
        .DEBUG_RUN(dbg), .START_EVENT(ev[4]), .FLUSH_EVENT(ev[5]), .EVT_START_CONV(evt[0]),
        .EVT_FLUSH(evt[1]), .EVT_RESULT_READY(evt[2]), .EVT_WINDOW(evt[3]), .IRQ(irq));

    // ========================================
    // bus and stimulus tasks
    task automatic wr(input logic [5:0] a, input logic [1:0] s, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        size <= s;
        wdata <= d << (8 * a[1:0]);
        wr_stb <= 1'b1;
        @(posedge mclk);
        wr_stb <= 1'b0;
        #1;
    endtask : wr

    task automatic expect_rd(input logic [5:0] a, input logic [1:0] s, input logic [31:0] e);
        logic [31:0] d;
        @(posedge mclk);
        addr <= a;
        size <= s;
        rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        #1;
        d = rdata >> (8 * a[1:0]);
        `CHK($sformatf("read %h", a), e, d)
    endtask : expect_rd

    task automatic pulse(input logic [5:0] v, input logic [3:0] e);
        @(posedge mclk);
        ev <= v;
        #1;
        `CHK("events", e, evt)
        @(posedge mclk);
        ev <= 6'h00;
        #1;
    endtask : pulse

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish

    // ========================================
    // clock, reset, timeout
    initial begin
        forever #25 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            tally_and_finish();
        end
    end

    // ========================================
    // tests
    initial begin
        logic [31:0] d;
        logic [7:0] v;
        logic [5:0] offs [8];
        int n;
        offs = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h14, 6'h18, 6'h05, 6'h15};
        void'($urandom(32'h87E0));
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        res_data <= $urandom;
        foreach (offs[i]) expect_rd(offs[i], 2'h0, 32'h0);
        $display("end reset values");
        for (int c = 0; c < 16; c++) begin
            v = $urandom;
            wr(6'h01, 2'h0, {v[7:4], c[3:0]});
            wr(6'h02, 2'h0, {v[7:4], c[3:0]});
            `CHK("ref ok", c <= 4, ref_ok)
            `CHK("ref sel", c[3:0], ref_sel)
            `CHK("ref comp", v[7], ref_comp)
            `CHK("acc ok", c <= 10, acc_ok)
            `CHK("acc", c[3:0], acc_cnt)
            `CHK("shift", v[6:4], shift)
            expect_rd(6'h01, 2'h0, {v[7], 3'h0, c[3:0]});
        end
        d = $urandom;
        wr(6'h00, 2'h2, {d[31:8], 8'h00});
        expect_rd(6'h00, 2'h2, {d[31:24] & 8'h3F, d[23:16] & 8'h7F, d[15:8] & 8'h8F, 8'h00});
        expect_rd(6'h02, 2'h1, {d[31:24] & 8'h3F, d[23:16] & 8'h7F});
        wr(6'h1C, 2'h1, d[15:0]);
        expect_rd(6'h1D, 2'h0, d[15:8]);
        `CHK("win low", d[15:0], win_lo)
        @(posedge mclk);
        lock <= 1'b1;
        wr(6'h01, 2'h0, ~d[15:8]);
        expect_rd(6'h01, 2'h0, d[15:8] & 8'h8F);
        lock <= 1'b0;
        $display("end access sizes");
        wr(6'h14, 2'h0, 32'hFF);
        expect_rd(6'h14, 2'h0, 32'h33);
        wr(6'h17, 2'h0, 32'h08);
        wr(6'h00, 2'h0, 32'h02);
        wr(6'h20, 2'h1, 32'hA5C3);
        `CHK("stall", 1'b1, stall)
        expect_rd(6'h00, 2'h0, 32'h02);
        for (int i = 0; i < 20 && (stall || !conv_en); i++) @(posedge mclk);
        repeat (2 * SC) @(posedge mclk);
        `CHK("enabled", 1'b1, conv_en)
        expect_rd(6'h20, 2'h1, 32'hA5C3);
        expect_rd(6'h19, 2'h0, 32'h0);
        expect_rd(6'h18, 2'h0, 32'h08);
        `CHK("irq", 1'b1, irq)
        wr(6'h18, 2'h0, 32'h08);
        `CHK("irq", 1'b0, irq)
        wr(6'h14, 2'h0, 32'h00);
        expect_rd(6'h14, 2'h0, 32'h33);
        pulse(6'h3F, 4'hF);
        expect_rd(6'h18, 2'h0, 32'h07);
        `CHK("irq", 1'b0, irq)
        wr(6'h17, 2'h0, 32'h02);
        `CHK("irq", 1'b1, irq)
        wr(6'h16, 2'h0, 32'h02);
        `CHK("irq", 1'b0, irq)
        expect_rd(6'h1A, 2'h1, res_data);
        $display("end enable and flags");
        @(posedge mclk);
        standby <= 1'b1;
        #1;
        `CHK("run", 1'b0, conv_run)
        wr(6'h00, 2'h0, 32'h06);
        repeat (2 * SC + 2) @(posedge mclk);
        #1;
        `CHK("run", 1'b1, conv_run)
        standby <= 1'b0;
        v = $urandom_range(0, 20);
        wr(6'h03, 2'h0, v);
        for (int i = 0; i < 300 && sampling; i++) @(posedge mclk);
        pulse(6'h08, 4'h0);
        n = 0;
        while (sampling && n < 300) begin
            @(posedge mclk);
            n++;
        end
        `CHK("sample len", 1'b1, n >= (v + 1) * 2 - 1 && n <= (v + 1) * 2 + 3)
        $display("end standby and sampling");
        wr(6'h2A, 2'h0, 32'h01);
        wr(6'h00, 2'h0, 32'h05);
        expect_rd(6'h00, 2'h0, 32'h05);
        repeat (2 * SC) @(posedge mclk);
        expect_rd(6'h19, 2'h0, 32'h0);
        expect_rd(6'h00, 2'h0, 32'h0);
        expect_rd(6'h01, 2'h0, 32'h0);
        expect_rd(6'h2A, 2'h0, 32'h01);
        `CHK("enabled", 1'b0, conv_en)
        `CHK("debug", 1'b1, dbg)
        $display("end soft reset");
        tally_and_finish();
    end
endmodule : tb_adc_control_register_bank
